// ==== src/process_loop_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module process_loop_controller #(
   parameter int TICK_CYCLES = ploop_pkg::TICK_CYCLES_DEF
) (
   input  wire logic        CLK_I,
   input  wire logic        RSTN_I,
   input  wire logic [1:0]  LOOP_MODE_SELECT_I,
   input  wire logic [15:0] PROPORTIONAL_GAIN_I,
   input  wire logic [15:0] INTEGRAL_GAIN_I,
   input  wire logic [15:0] DERIVATIVE_GAIN_I,
   input  wire logic [15:0] VALUE_SCALE_FACTOR_I,
   input  wire logic [7:0]  FEEDBACK_SOURCE_SELECT_I,
   input  wire logic [1:0]  DEVIATION_INVERT_I,
   input  wire logic [9:0]  OUTPUT_BAND_LIMIT_I,
   input  wire logic [1:0]  FEEDFORWARD_SOURCE_SELECT_I,
   input  wire logic [7:0]  FREQUENCY_REFERENCE_SELECT_I,
   input  wire logic [1:0]  ANALOG_INPUT_SELECT_I,
   input  wire logic [9:0]  DEVIATION_ALARM_LEVEL_I,
   input  wire logic [9:0]  FEEDBACK_WINDOW_OFF_LEVEL_I,
   input  wire logic [9:0]  FEEDBACK_WINDOW_ON_LEVEL_I,
   input  wire logic [15:0] SLEEP_LEVEL_I,
   input  wire logic [7:0]  SLEEP_DELAY_I,
   input  wire logic [1:0]  STOP_METHOD_SELECT_I,
   input  wire logic [15:0] PULSE_SCALE_I,
   input  wire logic [15:0] VOLTAGE_ANALOG_I,
   input  wire logic [15:0] CURRENT_ANALOG_I,
   input  wire logic [15:0] PULSE_FREQUENCY_I,
   input  wire logic [15:0] DIGITAL_TARGET_I,
   input  wire logic        INTEGRAL_CLEAR_INPUT_I,
   input  wire logic        CONTROL_INHIBIT_I,
   input  wire logic [15:0] HR_ADDR_I,
   input  wire logic [15:0] HR_WDATA_I,
   input  wire logic        HR_WRITE_I,
   input  wire logic        HR_READ_I,
   output logic      [15:0] HR_RDATA_O,
   output logic             HR_RVALID_O,
   output logic             HR_ERROR_O,
   output logic      [15:0] FREQUENCY_COMMAND_O,
   output logic             REVERSE_O,
   output logic             EXCESS_DEVIATION_FLAG_O,
   output logic             FEEDBACK_WINDOW_FLAG_O,
   output logic      [23:0] FEEDBACK_MONITOR_O,
   output logic      [23:0] SCALED_TARGET_O,
   output logic             SLEEP_STOP_O,
   output logic             STOP_FREE_RUN_O
);
   import ploop_pkg::*;

   typedef struct packed {
      logic [15:0]        hr_value;
      logic [2:0]         ic_sync;
      logic [2:0]         inh_sync;
      logic               ic_lvl;
      logic               inh_lvl;
      logic [31:0]        tick_cnt;
      logic signed [23:0] acc;
      logic signed [17:0] prev_dev;
      logic [15:0]        cmd;
      logic               reverse;
      logic               excess;
      logic               window;
      logic [23:0]        monitor;
      logic [23:0]        scaled_target;
      sleep_state_t       sleep_st;
      logic [15:0]        sleep_cnt;
      logic               sleep_stop;
      logic               free_run;
      logic [15:0]        rdata;
      logic               rvalid;
      logic               rerror;
   } state_t;

   state_t s;
   state_t next_s;

   always_comb begin
      logic               tick;
      logic               active;
      logic               ic_rise;
      logic               below;
      logic [15:0]        pulse_pct;
      logic [29:0]        pulse_q;
      logic [15:0]        tgt;
      logic [15:0]        fb;
      logic [15:0]        ffv;
      logic signed [17:0] dev;
      logic signed [18:0] ddev;
      logic [17:0]        adev;
      logic signed [24:0] acc_sum;
      logic signed [23:0] acc_new;
      logic signed [41:0] pp;
      logic signed [41:0] ip;
      logic signed [41:0] dp;
      logic signed [25:0] u;
      logic signed [25:0] bnd;
      logic signed [25:0] lo;
      logic signed [25:0] hi;
      logic [15:0]        lim;
      tick      = 1'b0;
      active    = 1'b0;
      ic_rise   = 1'b0;
      below     = 1'b0;
      pulse_pct = '0;
      pulse_q   = '0;
      tgt       = '0;
      fb        = '0;
      ffv       = '0;
      dev       = '0;
      ddev      = '0;
      adev      = '0;
      acc_sum   = '0;
      acc_new   = '0;
      pp        = '0;
      ip        = '0;
      dp        = '0;
      u         = '0;
      bnd       = '0;
      lo        = '0;
      hi        = '0;
      lim       = '0;
      next_s    = s;

      tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));
      next_s.tick_cnt = tick ? '0 : s.tick_cnt + 32'h1;

      // pin inputs: level accepted when stages two and three agree
      next_s.ic_sync  = {s.ic_sync[1:0], INTEGRAL_CLEAR_INPUT_I};
      next_s.inh_sync = {s.inh_sync[1:0], CONTROL_INHIBIT_I};
      if (s.ic_sync[2] == s.ic_sync[1]) begin
         next_s.ic_lvl = s.ic_sync[2];
      end
      if (s.inh_sync[2] == s.inh_sync[1]) begin
         next_s.inh_lvl = s.inh_sync[2];
      end
      ic_rise = next_s.ic_lvl & ~s.ic_lvl;

      // pulse train to percent, scale frequency = 100 %
      if (PULSE_SCALE_I != 16'h0000) begin
         pulse_q = (30'(PULSE_FREQUENCY_I) * 30'(FULL_SCALE)) / 30'(PULSE_SCALE_I); // R8
         pulse_pct = (pulse_q > 30'(FULL_SCALE)) ? FULL_SCALE : pulse_q[15:0];
      end

      unique case (FREQUENCY_REFERENCE_SELECT_I)
         FREF_TERMINAL:   tgt = VOLTAGE_ANALOG_I; // R5
         FREF_PULSE:      tgt = pulse_pct;
         FREF_ANALOG_SEL: tgt = (ANALOG_INPUT_SELECT_I == AIN_VOLTAGE) ? VOLTAGE_ANALOG_I : CURRENT_ANALOG_I;
         default:         tgt = DIGITAL_TARGET_I;
      endcase

      unique case (FEEDBACK_SOURCE_SELECT_I)
         FB_CURRENT: fb = CURRENT_ANALOG_I;
         FB_VOLTAGE: fb = VOLTAGE_ANALOG_I;
         FB_SERIAL:  fb = s.hr_value; // R6
         FB_PULSE:   fb = pulse_pct; // R8
         default:    fb = '0;
      endcase

      unique case (FEEDFORWARD_SOURCE_SELECT_I)
         FF_VOLTAGE: ffv = VOLTAGE_ANALOG_I; // R9
         FF_CURRENT: ffv = CURRENT_ANALOG_I; // R9
         default:    ffv = '0;
      endcase

      dev = $signed({2'b00, tgt}) - $signed({2'b00, fb}); // R1
      if (DEVIATION_INVERT_I == INVERT_ON) begin
         dev = -dev; // R10
      end
      adev = dev[17] ? 18'(-dev) : 18'(dev);
      active = (LOOP_MODE_SELECT_I != MODE_OFF) && !s.inh_lvl; // R22 R23

      acc_sum = s.acc + dev; // R2
      if (acc_sum > 25'(ACC_MAX)) begin
         acc_new = ACC_MAX;
      end else if (acc_sum < -25'(ACC_MAX)) begin
         acc_new = -ACC_MAX;
      end else begin
         acc_new = acc_sum[23:0];
      end
      ddev = dev - s.prev_dev; // R3
      pp = $signed({1'b0, PROPORTIONAL_GAIN_I}) * dev; // R1
      ip = $signed({1'b0, INTEGRAL_GAIN_I}) * acc_new; // R2
      dp = $signed({1'b0, DERIVATIVE_GAIN_I}) * ddev; // R3
      u = 26'(pp >>> GAIN_FRAC) + 26'(ip >>> GAIN_FRAC) + 26'(dp >>> GAIN_FRAC)
          + $signed({10'h000, ffv}); // R26

      bnd = 26'({OUTPUT_BAND_LIMIT_I, 3'b000}) + 26'({OUTPUT_BAND_LIMIT_I, 1'b0});
      lo = $signed({10'h000, tgt}) - bnd;
      hi = $signed({10'h000, tgt}) + bnd;
      if (LOOP_MODE_SELECT_I != MODE_REVERSE && OUTPUT_BAND_LIMIT_I != 10'h000) begin // R11 R13
         if (u > hi) begin
            u = hi;
         end else if (u < lo) begin
            u = lo;
         end
      end
      if (u > $signed({10'h000, FULL_SCALE})) begin
         u = $signed({10'h000, FULL_SCALE});
      end else if (u < -$signed({10'h000, FULL_SCALE})) begin
         u = -$signed({10'h000, FULL_SCALE});
      end

      if (tick) begin
         if (!active) begin
            next_s.acc     = '0;
            next_s.cmd     = tgt; // R23
            next_s.reverse = 1'b0;
         end else begin
            next_s.acc = acc_new;
            if (u < 26'sh0) begin
               next_s.reverse = (LOOP_MODE_SELECT_I == MODE_REVERSE); // R13
               next_s.cmd     = next_s.reverse ? 16'(-u) : 16'h0000; // R12
            end else begin
               next_s.reverse = 1'b0;
               next_s.cmd     = u[15:0];
            end
         end
         next_s.prev_dev = dev;
         next_s.excess   = active && (adev >= 18'({DEVIATION_ALARM_LEVEL_I, 3'b000})
                                      + 18'({DEVIATION_ALARM_LEVEL_I, 1'b0})); // R14
         next_s.window   = (fb < 16'({FEEDBACK_WINDOW_ON_LEVEL_I, 3'b000})
                            + 16'({FEEDBACK_WINDOW_ON_LEVEL_I, 1'b0}))
                           || (fb > 16'({FEEDBACK_WINDOW_OFF_LEVEL_I, 3'b000})
                            + 16'({FEEDBACK_WINDOW_OFF_LEVEL_I, 1'b0})); // R15 R24
         next_s.monitor       = 24'((32'(fb) * 32'(VALUE_SCALE_FACTOR_I)) / 32'd100); // R4 R16
         next_s.scaled_target = 24'((32'(tgt) * 32'(VALUE_SCALE_FACTOR_I)) / 32'd100); // R4

         // sleep compares the new frequency command, loop or not
         below = next_s.cmd < SLEEP_LEVEL_I; // R19 R21
         lim   = 16'(32'(SLEEP_DELAY_I) * 32'(TICKS_PER_UNIT)); // R25
         unique case (s.sleep_st)
            SLP_RUN: begin
               if (below) begin
                  next_s.sleep_cnt = 16'h0001;
                  next_s.free_run  = (STOP_METHOD_SELECT_I == STOP_FREE_RUN);
                  next_s.sleep_st  = (lim <= 16'h0001) ? SLP_STOP : SLP_WAIT;
               end
            end
            SLP_WAIT: begin
               if (!below) begin
                  next_s.sleep_st = SLP_RUN; // R20
               end else begin
                  next_s.sleep_cnt = s.sleep_cnt + 16'h0001;
                  if (next_s.sleep_cnt >= lim) begin
                     next_s.sleep_st = SLP_STOP; // R19
                  end
               end
            end
            SLP_STOP: begin
               if (!below) begin
                  next_s.sleep_st = SLP_RUN;
               end
            end
            default: next_s.sleep_st = SLP_RUN;
         endcase
         next_s.sleep_stop = (next_s.sleep_st == SLP_STOP);
      end

      // clear edge wins over any accumulation in the same cycle
      if (ic_rise) begin
         next_s.acc = '0; // R17
      end

      next_s.rvalid = 1'b0;
      next_s.rerror = 1'b0;
      if (HR_READ_I) begin
         if (HR_ADDR_I == HR_FEEDBACK_ADDR && FEEDBACK_SOURCE_SELECT_I == FB_SERIAL) begin
            next_s.rdata  = s.hr_value; // R7
            next_s.rvalid = 1'b1;
         end else begin
            next_s.rdata  = '0; // R7
            next_s.rerror = 1'b1;
         end
      end
      if (HR_WRITE_I) begin
         if (HR_ADDR_I == HR_FEEDBACK_ADDR) begin
            next_s.hr_value = HR_WDATA_I; // R6
         end else begin
            next_s.rerror = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         s          <= '0;
         s.hr_value <= HR_FEEDBACK_RESET;
         s.sleep_st <= SLP_RUN;
      end else begin
         s <= next_s;
      end
   end

   assign HR_RDATA_O              = s.rdata;
   assign HR_RVALID_O             = s.rvalid;
   assign HR_ERROR_O              = s.rerror;
   assign FREQUENCY_COMMAND_O     = s.cmd;
   assign REVERSE_O               = s.reverse;
   assign EXCESS_DEVIATION_FLAG_O = s.excess;
   assign FEEDBACK_WINDOW_FLAG_O  = s.window;
   assign FEEDBACK_MONITOR_O      = s.monitor;
   assign SCALED_TARGET_O         = s.scaled_target;
   assign SLEEP_STOP_O            = s.sleep_stop;
   assign STOP_FREE_RUN_O         = s.free_run;
endmodule : process_loop_controller
`default_nettype wire

// ==== src/ploop_pkg.sv ====
// How it works
// (R1) proportional term is gain times deviation
// (R2) integral term from accumulated deviation
// (R3) derivative term from deviation change
// (R4) scaled values equal value times scale
// (R5) target from reference select, analog select ignored; the code uses analog select when reference select is 00
// (R6) serial feedback in holding register serial_feedback_value
// (R7) holding register readable only in serial mode
// (R8) pulse frequency converted to percent feedback
// (R9) feedforward added unless its select disabled
// (R10) invert setting 01 negates the deviation
// (R11) output clamped to target plus/minus band
// (R12) normal mode floors negative output at zero
// (R13) mode 02 passes reverse, band clamp off
// (R14) excess flag when deviation reaches alarm level
// (R15) window flag when feedback leaves range
// (R16) monitor equals feedback times scale factor
// (R17) integral cleared when clear input turns on
// (R18) clear input only with loop stopped; the code clears the integral on a clear edge in any mode
// (R19) sleep stop after delay below level
// (R20) recovery before delay cancels the sleep
// (R21) sleep also applies with loop disabled
// (R22) mode codes 00 off, 01 on, 02 reverse
// (R23) inhibit input bypasses loop to normal reference
// (R24) window on/off levels 0.0 to 100.0 percent
// (R25) sleep delay 0.0 to 25.5 seconds
// (R26) terms summed once per control tick
package ploop_pkg;
   localparam logic [15:0] HR_FEEDBACK_ADDR  = 16'h0006;
   localparam logic [15:0] HR_FEEDBACK_RESET = 16'h0000;
   localparam logic [15:0] FULL_SCALE        = 16'h2710;
   localparam logic [1:0]  MODE_OFF          = 2'h0;
   localparam logic [1:0]  MODE_ON           = 2'h1;
   localparam logic [1:0]  MODE_REVERSE      = 2'h2;
   localparam logic [7:0]  FB_CURRENT        = 8'h00;
   localparam logic [7:0]  FB_VOLTAGE        = 8'h01;
   localparam logic [7:0]  FB_SERIAL         = 8'h02;
   localparam logic [7:0]  FB_PULSE          = 8'h03;
   localparam logic [7:0]  FREF_ANALOG_SEL   = 8'h00;
   localparam logic [7:0]  FREF_TERMINAL     = 8'h01;
   localparam logic [7:0]  FREF_PULSE        = 8'h06;
   localparam logic [1:0]  AIN_VOLTAGE       = 2'h0;
   localparam logic [1:0]  FF_VOLTAGE        = 2'h1;
   localparam logic [1:0]  FF_CURRENT        = 2'h2;
   localparam logic [1:0]  INVERT_ON         = 2'h1;
   localparam logic [1:0]  STOP_FREE_RUN     = 2'h1;
   localparam int          GAIN_FRAC         = 8;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          TICK_TIME_US      = 1000;
   localparam int          TICK_CYCLES_DEF   = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int          SLEEP_UNIT_MS     = 100;
   localparam int          TICKS_PER_UNIT    = SLEEP_UNIT_MS * 1000 / TICK_TIME_US;
   localparam logic signed [23:0] ACC_MAX    = 24'sh3FFFFF;

   typedef enum logic [1:0] {
      SLP_RUN  = 2'b00,
      SLP_WAIT = 2'b01,
      SLP_STOP = 2'b10
   } sleep_state_t;
endpackage : ploop_pkg

// ==== verification/ploop_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ploop_properties #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic        CLK_I,
   input wire logic        RSTN_I,
   input wire logic [1:0]  LOOP_MODE_SELECT_I,
   input wire logic [7:0]  FEEDBACK_SOURCE_SELECT_I,
   input wire logic [15:0] HR_ADDR_I,
   input wire logic        HR_WRITE_I,
   input wire logic        HR_READ_I,
   input wire logic [15:0] HR_RDATA_O,
   input wire logic        HR_RVALID_O,
   input wire logic        HR_ERROR_O,
   input wire logic [15:0] FREQUENCY_COMMAND_O,
   input wire logic        REVERSE_O,
   input wire logic        EXCESS_DEVIATION_FLAG_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);
   sequence s_good_read;
      HR_READ_I && HR_ADDR_I == 16'h0006 && FEEDBACK_SOURCE_SELECT_I == 8'h02;
   endsequence
   sequence s_bad_read;
      HR_READ_I && (HR_ADDR_I != 16'h0006 || FEEDBACK_SOURCE_SELECT_I != 8'h02);
   endsequence
   property p_good_read; s_good_read |=> HR_RVALID_O && !HR_ERROR_O; endproperty
   property p_bad_read; s_bad_read |=> HR_ERROR_O && !HR_RVALID_O && HR_RDATA_O == 16'h0000; endproperty
   property p_write_quiet;
      HR_WRITE_I && !HR_READ_I && HR_ADDR_I == 16'h0006 |=> !HR_ERROR_O && !HR_RVALID_O;
   endproperty
   property p_idle_quiet; !HR_READ_I && !HR_WRITE_I |=> !HR_RVALID_O && !HR_ERROR_O; endproperty
   property p_cmd_limit; FREQUENCY_COMMAND_O <= 16'h2710; endproperty
   property p_stand; $changed(FREQUENCY_COMMAND_O) |=> $stable(FREQUENCY_COMMAND_O) [*2]; endproperty
   property p_no_rev; (LOOP_MODE_SELECT_I != 2'h2) [*8] |-> !REVERSE_O; endproperty
   property p_idle_excess; (LOOP_MODE_SELECT_I == 2'h0) [*8] |-> !EXCESS_DEVIATION_FLAG_O; endproperty
   a_good_read: assert property (p_good_read) else $error("good read not answered");
   a_bad_read: assert property (p_bad_read) else $error("bad read not refused");
   a_write_quiet: assert property (p_write_quiet) else $error("write answered");
   a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");
   a_cmd_limit: assert property (p_cmd_limit) else $error("command above full scale");
   a_stand: assert property (p_stand) else $error("command changed between ticks");
   a_no_rev: assert property (p_no_rev) else $error("reverse outside reverse mode");
   a_idle_excess: assert property (p_idle_excess) else $error("excess flag with loop off");
endmodule : ploop_properties
bind process_loop_controller ploop_properties #(.TICK_CYCLES(TICK_CYCLES)) ploop_properties_i (.*);
`default_nettype wire

// ==== verification/ploop_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ploop_field_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic        rvalid_i,
   input  wire logic        error_i,
   output logic      [15:0] volt_o,
   output logic      [15:0] curr_o,
   output logic      [15:0] pulse_o,
   output logic      [15:0] addr_o,
   output logic      [15:0] wdata_o,
   output logic             write_o,
   output logic             read_o
);
   initial begin
      {volt_o, curr_o, pulse_o, addr_o, wdata_o, write_o, read_o} = '0;
   end
   task automatic hr_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      write_o = 1'b1;
      @(negedge clk_i);
      write_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : hr_write
   task automatic hr_read(input logic [15:0] a, output logic [15:0] d, output logic v, output logic e);
      @(negedge clk_i);
      addr_o = a;
      read_o = 1'b1;
      @(negedge clk_i);
      d = rdata_i;
      v = rvalid_i;
      e = error_i;
      read_o = 1'b0;
      addr_o = ~a;
   endtask : hr_read
endmodule : ploop_field_model
`default_nettype wire

// ==== verification/tb_process_loop_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_process_loop_controller;
   import ploop_pkg::*;
   localparam int TK = 4;
   logic        clk, rstn, clr, inh, wr, rq, rv, er, rev, exf, wnf, slp, frun;
   logic [1:0]  mode, inv, ffsel, ainsel, stopm;
   logic [7:0]  fbsel, frsel, sdly;
   logic [9:0]  band, alarm, woff, won;
   logic [15:0] kp, ki, kd, scale, slvl, pscale, tgt, volt, curr, pf, addr, wd, rd, cmd, d;
   logic [23:0] mon, stgt;
   logic        v, e;
   int          failures, checks;
   process_loop_controller #(.TICK_CYCLES(TK)) process_loop_controller_i (
      .CLK_I(clk), .RSTN_I(rstn), .LOOP_MODE_SELECT_I(mode), .PROPORTIONAL_GAIN_I(kp), .INTEGRAL_GAIN_I(ki),
      .DERIVATIVE_GAIN_I(kd), .VALUE_SCALE_FACTOR_I(scale), .FEEDBACK_SOURCE_SELECT_I(fbsel),
      .DEVIATION_INVERT_I(inv), .OUTPUT_BAND_LIMIT_I(band), .FEEDFORWARD_SOURCE_SELECT_I(ffsel),
      .FREQUENCY_REFERENCE_SELECT_I(frsel), .ANALOG_INPUT_SELECT_I(ainsel), .DEVIATION_ALARM_LEVEL_I(alarm),
      .FEEDBACK_WINDOW_OFF_LEVEL_I(woff), .FEEDBACK_WINDOW_ON_LEVEL_I(won), .SLEEP_LEVEL_I(slvl),
      .SLEEP_DELAY_I(sdly), .STOP_METHOD_SELECT_I(stopm), .PULSE_SCALE_I(pscale), .VOLTAGE_ANALOG_I(volt),
      .CURRENT_ANALOG_I(curr), .PULSE_FREQUENCY_I(pf), .DIGITAL_TARGET_I(tgt), .INTEGRAL_CLEAR_INPUT_I(clr),
      .CONTROL_INHIBIT_I(inh), .HR_ADDR_I(addr), .HR_WDATA_I(wd), .HR_WRITE_I(wr), .HR_READ_I(rq),
      .HR_RDATA_O(rd), .HR_RVALID_O(rv), .HR_ERROR_O(er), .FREQUENCY_COMMAND_O(cmd), .REVERSE_O(rev),
      .EXCESS_DEVIATION_FLAG_O(exf), .FEEDBACK_WINDOW_FLAG_O(wnf), .FEEDBACK_MONITOR_O(mon),
      .SCALED_TARGET_O(stgt), .SLEEP_STOP_O(slp), .STOP_FREE_RUN_O(frun));
   ploop_field_model fld_i (.clk_i(clk), .rdata_i(rd), .rvalid_i(rv), .error_i(er), .volt_o(volt),
      .curr_o(curr), .pulse_o(pf), .addr_o(addr), .wdata_o(wd), .write_o(wr), .read_o(rq));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic settle;
      repeat (3 * TK) @(negedge clk);
   endtask : settle
   task automatic t_reg;
      fld_i.hr_write(16'h0006, 16'h0FA0);
      fld_i.hr_read(16'h0006, d, v, e);
      chk(v, 24'h1, "read valid");
      chk(d, 24'h0FA0, "read data");
      fbsel = FB_VOLTAGE;
      fld_i.hr_read(16'h0006, d, v, e);
      chk({e, d}, 24'h10000, "read other mode");
      fbsel = FB_SERIAL;
      fld_i.hr_read(16'h0007, d, v, e);
      chk(e, 24'h1, "read bad address");
      $display("test reg done");
   endtask : t_reg
   task automatic t_loop;
      mode = MODE_ON;
      alarm = 10'h0C8;
      settle();
      chk(cmd, 24'h07D0, "p term");
      chk(exf, 24'h1, "excess at level");
      alarm = 10'h0C9;
      inv = INVERT_ON;
      settle();
      chk({exf, rev, cmd}, 24'h0, "inverted floor");
      mode = MODE_REVERSE;
      settle();
      chk({rev, cmd}, 24'h107D0, "reverse out");
      {inv, kp, band, mode} = {2'h0, 16'h0400, 10'h00A, MODE_ON};
      settle();
      chk(cmd, 24'h17D4, "band clamp");
      mode = MODE_REVERSE;
      settle();
      chk(cmd, 24'h1F40, "band off in reverse");
      {mode, band} = {MODE_ON, 10'h000};
      inh = 1'b1;
      settle();
      chk(cmd, 24'h1770, "inhibit bypass");
      inh = 1'b0;
      $display("test loop done");
   endtask : t_loop
   task automatic t_ff_int;
      kp = 16'h0000;
      ffsel = FF_VOLTAGE;
      fld_i.volt_o = 16'h05DC;
      fld_i.curr_o = 16'h1B58;
      settle();
      chk(cmd, 24'h05DC, "feedforward");
      ffsel = 2'h0;
      settle();
      chk(cmd, 24'h0, "feedforward off");
      kd = 16'h0100;
      settle();
      chk(cmd, 24'h0, "derivative quiet");
      fld_i.hr_write(16'h0006, 16'h0BB8);
      // derivative kick stands one tick only
      for (int i = 0; i < 2 * TK && cmd == 16'h0000; i++) begin
         @(negedge clk);
      end
      chk(cmd, 24'h03E8, "derivative kick");
      settle();
      chk(cmd, 24'h0, "derivative settles");
      kd = 16'h0000;
      fld_i.hr_write(16'h0006, 16'h0FA0);
      {mode, frsel, ainsel} = {MODE_OFF, FREF_TERMINAL, 2'h1};
      settle();
      chk(cmd, 24'h05DC, "target source");
      frsel = 8'h02;
      clr = 1'b1;
      settle();
      {clr, ki, mode} = {1'b0, 16'h0100, MODE_ON};
      repeat (TK) @(negedge clk);
      d = cmd;
      chk(d, 24'h07D0, "integral first tick");
      repeat (TK) @(negedge clk);
      chk(cmd, d + 16'h07D0, "integral step");
      {ki, mode, kp} = {16'h0000, MODE_OFF, 16'h0100};
      $display("test ff int done");
   endtask : t_ff_int
   task automatic t_window;
      {mode, won} = {MODE_ON, 10'h1F4};
      settle();
      chk(wnf, 24'h1, "window low");
      {won, woff} = {10'h000, 10'h190};
      settle();
      chk(wnf, 24'h0, "window edge");
      {woff, scale} = {10'h12C, 16'h00FA};
      settle();
      chk(wnf, 24'h1, "window high");
      chk(mon, 24'h2710, "monitor scaled");
      chk(stgt, 24'h3A98, "scaled target");
      {fbsel, pscale} = {FB_PULSE, 16'h03E8};
      fld_i.pulse_o = 16'h00FA;
      settle();
      chk(mon, 24'h186A, "pulse monitor");
      {fbsel, scale, woff, mode} = {FB_SERIAL, 16'h0064, 10'h3E8, MODE_OFF};
      $display("test window done");
   endtask : t_window
   task automatic t_sleep;
      {tgt, slvl, stopm} = {16'h01F4, 16'h03E8, STOP_FREE_RUN};
      settle();
      chk({slp, frun}, 24'h3, "sleep loop off");
      {tgt, sdly} = {16'h07D0, 8'h02};
      settle();
      chk(slp, 24'h0, "sleep released");
      tgt = 16'h01F4;
      repeat (150 * TK) @(negedge clk);
      chk(slp, 24'h0, "sleep still waiting");
      tgt = 16'h07D0;
      settle();
      tgt = 16'h01F4;
      repeat (150 * TK) @(negedge clk);
      chk(slp, 24'h0, "recovery cancels");
      repeat (60 * TK) @(negedge clk);
      chk(slp, 24'h1, "sleep after delay");
      $display("test sleep done");
   endtask : t_sleep
   initial begin
      {rstn, clr, inh, mode, inv, ffsel, ainsel, stopm, band, sdly, slvl, won} = '0;
      {kp, ki, kd, scale, fbsel, frsel} = {16'h0100, 16'h0, 16'h0, 16'h0064, FB_SERIAL, 8'h02};
      {alarm, woff, pscale, tgt} = {10'h3E8, 10'h3E8, 16'h03E8, 16'h1770};
      {failures, checks} = '0;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      t_reg();
      t_loop();
      t_ff_int();
      t_window();
      t_sleep();
      print_verdict();
   end
   initial begin
      #500000;
      failures++;
      print_verdict();
   end
endmodule : tb_process_loop_controller
`default_nettype wire
